//--- common/motor_ctrl_pkg.sv
// constants, field positions and carriers of the motor control register block
// assumes one 100 MHz clock and a single AHB-Lite master
// Contract
// - demag register compares or captures demag count
// - speed mode compares demag against speed counter
// - zero event in auto mode loads gain times capture over 256
// - prescaler upper nibble is current sampling ratio
// - prescaler lower nibble steps on ratio events
// - mask bits enable the interrupt sources; bit 5 serves both ratio flags, bit 6 the speed error
// - overcurrent flag only in voltage mode
// - demag interrupt needs a demag mode enabled
// - pwm update flag set on preload transfer
// - switched ratio up increments, shifts right
// - switched ratio down decrements, shifts left
// - ratio bits pending flags in auto/speed modes
// - status bits 4..0 show pending flags
// - writing all ones resynchronises the pwm
// - auto mode flags cleared only, never set
// - outputs held in reset state while disabled
// - zero sampling continues per hold select
// - clock enable low stops events and preloads
// - register writes accepted with clocks off
// - flag interrupts only when enabled, unmasked
package motor_ctrl_pkg;
    // ==========================================
    // register byte offsets
    localparam logic [7:0] OFS_DEMAG = 8'h00;
    localparam logic [7:0] OFS_GAIN = 8'h04;
    localparam logic [7:0] OFS_PRESC = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0C;
    localparam logic [7:0] OFS_FLAG = 8'h10;
    localparam logic [7:0] OFS_CTRLA = 8'h14;
    localparam logic [7:0] OFS_AUX = 8'h18;
    localparam logic [7:0] OFS_SPDST = 8'h1C;
    localparam logic [7:0] OFS_NCC = 8'h20;
    // ==========================================
    // field positions (flag and mask share them)
    localparam int B_PWM = 7;
    localparam int B_RUP = 6;
    localparam int B_RDN = 5;
    localparam int B_OC = 4;
    localparam int B_EMG = 3;
    localparam int B_ZC = 2;
    localparam int B_DEM = 1;
    localparam int B_COM = 0;
    localparam int B_SPDERR = 6;
    localparam int CA_OUT_EN = 7;
    localparam int CA_CLK_EN = 6;
    localparam int CA_HALL = 5;
    localparam int CA_CUR_MODE = 3;
    localparam int CA_AUTO = 2;
    localparam int CA_ZCAP = 0;
    localparam int AX_HW_DEM = 0;
    localparam int AX_EMU_DEM = 1;
    localparam int AX_PWM_RATE = 2;
    localparam int AX_ZHOLD = 3;
    localparam int AX_FB_LO = 4;
    // ==========================================
    // values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RESYNC_VAL = 8'hFF;
    localparam logic [3:0] STEP_MAX = 4'hF;
    localparam logic [1:0] RS_HIZ = 2'h0;
    localparam logic [1:0] RS_HIGH = 2'h1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // events from the detectors, sampled on core_clk
    typedef struct packed {
        logic zero_cross;
        logic demag_end;
        logic commutation;
        logic emergency;
        logic current_at_limit;
        logic pwm_transfer_done;
        logic ratio_inc;
        logic ratio_dec;
        logic [7:0] demag_count;
        logic [7:0] zero_cur;
        logic [7:0] zero_prev;
        logic [7:0] speed_counter;
    } motor_evt_t;
endpackage

//--- logic/motor_ctrl_regs.sv
// interrupt, control and multiplier registers of the motor controller
// assumes detector events synchronous to core_clk, one AHB-Lite master
`timescale 1ns/1ps
`default_nettype none
module motor_ctrl_regs
    import motor_ctrl_pkg::*;
(
    input wire logic core_clk, // 100 MHz
    input wire logic rst_n, // async reset
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // word size for writes only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    output logic [31:0] hrdata, // read data
    input wire motor_evt_t evt, // detector events
    input wire logic global_irq_mask, // cpu mask, high blocks
    input wire logic [1:0] reset_state_opt, // output reset option
    input wire logic [5:0] phase_drive, // pwm phase levels
    output logic [5:0] phase_outputs, // phase pin levels
    output logic [5:0] phase_oe, // phase pin enables
    output logic irq, // interrupt request
    output logic pwm_resync, // counter reset and preload pulse
    output logic periph_clk_en, // internal clocks running
    output logic zero_sample_en, // zero sampling runs
    output logic demag_sample_en, // demag sampling runs
    output logic timer_shift_right, // one-cycle pulse
    output logic timer_shift_left, // one-cycle pulse
    output logic [3:0] current_mode_tick_ratio, // sampling ratio
    output logic [7:0] next_commutation_compare // multiplier result
);
    // ==========================================
    // registers
    logic [7:0] demag_q, gain_q, presc_q, mask_q, flag_q, ctrla_q, aux_q;
    logic [7:0] flag_d, ncc_q;
    logic spd_err_q, spd_ge_q, emu_eq_q, oc_prev_q;
    logic wr_pend_q, rd_pend_q, ready_q, irq_q, resync_q;
    logic shr_q, shl_q;
    logic [7:0] addr_q;
    logic [31:0] rdata_q;
    logic [5:0] pout_q, poe_q;

    // keeps only the bits that software writes as 1; a 0 clears
    function automatic logic [7:0] keep_ones(input logic [7:0] cur,
                                             input logic [7:0] wd);
        keep_ones = cur & wd;
    endfunction

    // ==========================================
    // bus decode
    wire addr_take = hsel & htrans[1] & hready;
    wire wr_take = addr_take & hwrite & (hsize == HSIZE_WORD);
    wire rd_take = addr_take & ~hwrite;
    wire [7:0] wd = hwdata[7:0];
    wire wr_demag = wr_pend_q & (addr_q == OFS_DEMAG);
    wire wr_gain = wr_pend_q & (addr_q == OFS_GAIN);
    wire wr_presc = wr_pend_q & (addr_q == OFS_PRESC);
    wire wr_mask = wr_pend_q & (addr_q == OFS_MASK);
    wire wr_flag = wr_pend_q & (addr_q == OFS_FLAG);
    wire wr_ctrla = wr_pend_q & (addr_q == OFS_CTRLA);
    wire wr_aux = wr_pend_q & (addr_q == OFS_AUX);
    wire wr_spdst = wr_pend_q & (addr_q == OFS_SPDST);
    wire wr_resync = wr_flag & (wd == RESYNC_VAL);

    // read mux; unmapped offsets read as zero
    logic [7:0] rd_byte;
    always_comb begin
        case (addr_q)
            OFS_DEMAG: rd_byte = demag_q;
            OFS_GAIN: rd_byte = gain_q;
            OFS_PRESC: rd_byte = presc_q;
            OFS_MASK: rd_byte = mask_q;
            OFS_FLAG: rd_byte = flag_q;
            OFS_CTRLA: rd_byte = ctrla_q;
            OFS_AUX: rd_byte = aux_q;
            OFS_SPDST: rd_byte = {1'b0, spd_err_q, 6'h00};
            OFS_NCC: rd_byte = ncc_q;
            default: rd_byte = RST_BYTE;
        endcase
    end

    // ==========================================
    // mode decode
    wire cke = ctrla_q[CA_CLK_EN];
    wire phase_output_enable = ctrla_q[CA_OUT_EN];
    wire auto_commutation_select = ctrla_q[CA_AUTO];
    wire cur_mode = ctrla_q[CA_CUR_MODE];
    wire hw_demag_enable = aux_q[AX_HW_DEM];
    wire emulated_demag_enable = aux_q[AX_EMU_DEM];
    wire spd_mode = |aux_q[AX_FB_LO+1:AX_FB_LO];
    wire pend_mode = auto_commutation_select | spd_mode;
    wire sw_ratio = ~pend_mode;

    // detectors are silent while the internal clocks are off
    wire ev_zc = cke & evt.zero_cross;
    wire ev_com = cke & evt.commutation;
    wire ev_emg = cke & evt.emergency;
    wire ev_pwm = cke & evt.pwm_transfer_done;
    wire ev_hdem = cke & hw_demag_enable & evt.demag_end;
    wire spd_ge = evt.speed_counter >= demag_q;
    wire emu_eq = evt.speed_counter == demag_q;
    // demag value is a compare for emulation, not in speed mode
    wire ev_edem = cke & emulated_demag_enable & ~spd_mode & emu_eq & ~emu_eq_q;
    wire ev_spd = cke & spd_mode & spd_ge & ~spd_ge_q;
    wire oc_rise = cke & evt.current_at_limit & ~oc_prev_q;

    // switched mode ratio actions at commutation; both set means none
    wire both_ratio = flag_q[B_RUP] & flag_q[B_RDN];
    wire sw_inc = sw_ratio & ev_com & flag_q[B_RUP] & ~both_ratio;
    wire sw_dec = sw_ratio & ev_com & flag_q[B_RDN] & ~both_ratio;
    wire r_up = sw_inc | (pend_mode & cke & evt.ratio_inc);
    wire r_dn = sw_dec | (pend_mode & cke & evt.ratio_dec);

    // hardware set vector of the flag register
    logic [7:0] hw_set;
    assign hw_set[B_PWM] = ev_pwm | wr_resync;
    assign hw_set[B_RUP] = pend_mode & cke & evt.ratio_inc;
    assign hw_set[B_RDN] = pend_mode & cke & evt.ratio_dec;
    assign hw_set[B_OC] = oc_rise & ~cur_mode;
    assign hw_set[B_EMG] = ev_emg;
    assign hw_set[B_ZC] = ev_zc;
    assign hw_set[B_DEM] = ev_hdem | ev_edem;
    assign hw_set[B_COM] = ev_com;

    // software side: write 0 clears, write 1 keeps, ratio bits taken as written in switched mode; all-ones is resync only
    logic [7:0] flag_sw;
    always_comb begin
        flag_sw = flag_q;
        if (wr_flag & ~wr_resync) begin
            flag_sw = keep_ones(flag_q, wd);
            if (sw_ratio) begin
                flag_sw[B_RUP] = wd[B_RUP];
                flag_sw[B_RDN] = wd[B_RDN];
            end
        end
        if (sw_ratio & ev_com) begin
            flag_sw[B_RUP] = 1'b0;
            flag_sw[B_RDN] = 1'b0;
        end
    end
    assign flag_d = flag_sw | hw_set;

    // interrupt enables per flag
    logic [7:0] irq_en;
    assign irq_en[B_PWM] = mask_q[B_PWM];
    assign irq_en[B_RUP] = mask_q[B_RDN] & pend_mode;
    assign irq_en[B_RDN] = mask_q[B_RDN] & pend_mode;
    assign irq_en[B_OC] = mask_q[B_OC];
    assign irq_en[B_EMG] = mask_q[B_EMG];
    assign irq_en[B_ZC] = mask_q[B_ZC];
    assign irq_en[B_DEM] = mask_q[B_DEM] & (hw_demag_enable | emulated_demag_enable);
    assign irq_en[B_COM] = mask_q[B_COM];
    wire irq_d = ~global_irq_mask &
        ((|(flag_q & irq_en)) | (mask_q[B_SPDERR] & spd_err_q));

    // multiplier: 8x8 product, upper byte is the divide by 256
    wire [7:0] zsel = ctrla_q[CA_ZCAP] ? evt.zero_cur : evt.zero_prev;
    wire [15:0] product = gain_q * zsel;
    wire ncc_load = auto_commutation_select & ev_zc;

    // step ratio saturates so an extra event cannot wrap the prescaler
    logic [3:0] step_d;
    always_comb begin
        step_d = presc_q[3:0];
        if (r_up & ~r_dn & (presc_q[3:0] != STEP_MAX)) begin
            step_d = presc_q[3:0] + 4'h1;
        end else if (r_dn & ~r_up & (presc_q[3:0] != 4'h0)) begin
            step_d = presc_q[3:0] - 4'h1;
        end
    end

    // zero sampling with outputs, hall and pwm rate bits off follows the hold select
    wire zhold_case = ~phase_output_enable & ~ctrla_q[CA_HALL] & ~aux_q[AX_PWM_RATE];
    wire zs_d = cke & (~zhold_case | aux_q[AX_ZHOLD]);

    // ==========================================
    // bus slave state: reads take one wait state so a write just
    // before them is already visible
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            ready_q <= 1'b1;
            addr_q <= RST_BYTE;
            rdata_q <= 32'h0000_0000;
        end else begin
            wr_pend_q <= wr_take;
            rd_pend_q <= rd_take;
            ready_q <= ~rd_take;
            if (addr_take) begin
                addr_q <= {haddr[7:2], 2'b00};
            end
            if (rd_pend_q) begin
                rdata_q <= {24'h00_0000, rd_byte};
            end
        end
    end

    // software registers; writes land whatever the clock enable
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gain_q <= RST_BYTE;
            mask_q <= RST_BYTE;
            ctrla_q <= RST_BYTE;
            aux_q <= RST_BYTE;
        end else begin
            if (wr_gain) gain_q <= wd;
            if (wr_mask) mask_q <= wd;
            if (wr_ctrla) ctrla_q <= wd;
            if (wr_aux) aux_q <= wd;
        end
    end

    // demag value: software write first, else hardware capture
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            demag_q <= RST_BYTE;
        end else if (wr_demag) begin
            demag_q <= wd;
        end else if (ev_hdem & ~spd_mode) begin
            demag_q <= evt.demag_count;
        end
    end

    // prescaler: upper nibble sampling ratio, lower step ratio
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            presc_q <= RST_BYTE;
        end else if (wr_presc) begin
            presc_q <= wd;
        end else begin
            presc_q <= {presc_q[7:4], step_d};
        end
    end

    // flags, speed error flag and edge history
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= RST_BYTE;
            spd_err_q <= 1'b0;
            spd_ge_q <= 1'b0;
            emu_eq_q <= 1'b0;
            oc_prev_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
            spd_err_q <= ev_spd | (spd_err_q & ~(wr_spdst & ~wd[B_SPDERR]));
            spd_ge_q <= spd_ge;
            emu_eq_q <= emu_eq;
            oc_prev_q <= evt.current_at_limit;
        end
    end

    // multiplier result and pulse outputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ncc_q <= RST_BYTE;
            irq_q <= 1'b0;
            resync_q <= 1'b0;
            shr_q <= 1'b0;
            shl_q <= 1'b0;
        end else begin
            if (ncc_load) ncc_q <= product[15:8];
            irq_q <= irq_d;
            resync_q <= wr_resync;
            shr_q <= sw_inc;
            shl_q <= sw_dec;
        end
    end

    // ==========================================
    // phase pins: driven when enabled, else option reset state
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_phase
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    pout_q[gi] <= 1'b0;
                    poe_q[gi] <= 1'b0;
                end else if (phase_output_enable) begin
                    pout_q[gi] <= phase_drive[gi];
                    poe_q[gi] <= 1'b1;
                end else begin
                    pout_q[gi] <= reset_state_opt == RS_HIGH;
                    poe_q[gi] <= reset_state_opt != RS_HIZ;
                end
            end
        end
    endgenerate

    // sampling enables registered so every output but the tied-off hresp is a flop
    logic zs_q, ds_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            zs_q <= 1'b0;
            ds_q <= 1'b0;
        end else begin
            zs_q <= zs_d;
            ds_q <= cke;
        end
    end

    assign hreadyout = ready_q;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;
    assign phase_outputs = pout_q;
    assign phase_oe = poe_q;
    assign irq = irq_q;
    assign pwm_resync = resync_q;
    assign periph_clk_en = ctrla_q[CA_CLK_EN];
    assign zero_sample_en = zs_q;
    assign demag_sample_en = ds_q;
    assign timer_shift_right = shr_q;
    assign timer_shift_left = shl_q;
    assign current_mode_tick_ratio = presc_q[7:4];
    assign next_commutation_compare = ncc_q;

    // ==========================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_read_addr;
        rd_take;
    endsequence
    sequence s_wait_then_ready;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence s_resync_write;
        wr_pend_q && addr_q == OFS_FLAG && hwdata[7:0] == RESYNC_VAL;
    endsequence

    read_wait_state_a: assert property (s_read_addr |=> s_wait_then_ready)
        else $error("read answer not after one wait state");
    set_beats_clear_a: assert property (
        cke && evt.commutation |=> flag_q[0])
        else $error("commutation event lost");
    auto_no_set_a: assert property (
        auto_commutation_select && wr_flag && hwdata[7:0] != 8'hFF && !flag_q[3] &&
        !(cke && evt.emergency) |=> !flag_q[3])
        else $error("software set a flag in auto mode");
    mult_load_a: assert property (
        auto_commutation_select && cke && evt.zero_cross |=> next_commutation_compare ==
        $past(product[15:8]))
        else $error("multiplier result not loaded");
    resync_pulse_a: assert property (
        s_resync_write |=> pwm_resync && flag_q[7])
        else $error("resync did not pulse or set update flag");
    irq_masked_a: assert property (
        global_irq_mask |=> !irq)
        else $error("interrupt while cpu mask set");
    oc_voltage_a: assert property (
        $rose(flag_q[4]) |-> !$past(ctrla_q[3]))
        else $error("overcurrent flag set in current mode");
    clk_off_quiet_a: assert property (
        !cke && !wr_pend_q |=> flag_q == $past(flag_q))
        else $error("event detected with clocks off");
    outputs_reset_a: assert property (
        !phase_output_enable [*2] |-> phase_oe == {6{$past(reset_state_opt) != RS_HIZ}})
        else $error("phase pins not in reset state");
    switched_up_a: assert property (
        !auto_commutation_select && !spd_mode && cke && evt.commutation && flag_q[6] &&
        !flag_q[5] && !wr_presc |=> timer_shift_right && !flag_q[6])
        else $error("switched ratio up not applied");
endmodule
`default_nettype wire

//--- test/motor_side_model.sv
// side model: event source of the feedback sensors and the pin wires
// assumes the bench asks for events one cycle ahead, on core_clk
`timescale 1ns/1ps
`default_nettype none
module motor_side_model
    import motor_ctrl_pkg::*;
(
    input wire logic core_clk, // block clock
    input wire motor_evt_t req, // requested events
    output motor_evt_t evt, // events to the block
    input wire logic [5:0] phase_outputs, // pin levels
    input wire logic [5:0] phase_oe, // pin enables
    output logic [5:0] pin_level // resolved wire levels
);
    logic [5:0] last_q = 6'h00;
    // ==========================================
    // sensors
    // detectors change just after an edge, as real comparators do
    always_ff @(posedge core_clk) begin
        evt <= req;
    end
    // ==========================================
    // wires
    // no pull resistors: a released pin toggles so a stale level never passes
    assign pin_level = (phase_oe & phase_outputs) | (~phase_oe & ~last_q);
    always_ff @(posedge core_clk) begin
        last_q <= pin_level;
    end
endmodule
`default_nettype wire

//--- test/tb_motor_ctrl_irq_and_control_regs.sv
// self-checking bench of the motor control register block
// assumes the side model is compiled before it, one AHB-Lite master
`timescale 1ns/1ps
`default_nettype none
module tb_motor_ctrl_irq_and_control_regs
    import motor_ctrl_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic gmask = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [1:0] htrans = 2'h0;
    logic [1:0] opt = 2'h0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [5:0] drive = 6'h2D;
    logic hreadyout, hresp, irq, resync, cke, zse, dse, shr, shl;
    logic [5:0] pins, oe, pinw;
    logic [3:0] ratio;
    logic [7:0] ncc;
    motor_evt_t req = '0;
    motor_evt_t evt;
    int failures = 0;
    int comparisons = 0;
    int nl = 0;
    int nr = 0;
    motor_ctrl_regs i_dut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .evt(evt), .global_irq_mask(gmask), .reset_state_opt(opt),
        .phase_drive(drive), .phase_outputs(pins), .phase_oe(oe), .irq(irq),
        .pwm_resync(resync), .periph_clk_en(cke), .zero_sample_en(zse),
        .demag_sample_en(dse), .timer_shift_right(shr), .timer_shift_left(shl),
        .current_mode_tick_ratio(ratio), .next_commutation_compare(ncc));
    motor_side_model i_side (.core_clk(core_clk), .req(req), .evt(evt),
        .phase_outputs(pins), .phase_oe(oe), .pin_level(pinw));
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    // shift pulses last one cycle, so they are counted where they stand
    always @(posedge core_clk) begin
        if (shl === 1'b1) nl = nl + 1;
        if (shr === 1'b1) nr = nr + 1;
    end
    // ==========================================
    // helpers
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("ERROR %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // one single transfer; waits on hready, no fixed latency assumed
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] q);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, {24'h0, e});
    endtask
    // k: 0 zero, 1 demag, 2 commutation, 3 halt, 4 limit, 5 pwm, 6 up, 7 down
    task automatic pulse(input int k);
        @(posedge core_clk);
        req[39-k] <= 1'b1;
        @(posedge core_clk);
        req[39-k] <= 1'b0;
        cyc(3);
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset;
        logic [7:0] ofs [8];
        ofs = '{OFS_DEMAG, OFS_GAIN, OFS_PRESC, OFS_MASK, OFS_FLAG, OFS_CTRLA,
                OFS_NCC, 8'h40};
        foreach (ofs[i]) rc(ofs[i], RST_BYTE);
        chk(oe, 6'h00);
        chk(hresp, 1'b0);
        $display("reset values done");
    endtask
    task automatic t_rw;
        wr(OFS_DEMAG, 8'hA5);
        rc(OFS_DEMAG, 8'hA5);
        wr(OFS_GAIN, 8'h3C);
        rc(OFS_GAIN, 8'h3C);
        wr(OFS_PRESC, 8'h92);
        rc(OFS_PRESC, 8'h92);
        chk(ratio, 4'h9);
        wr(OFS_MASK, 8'h5A);
        rc(OFS_MASK, 8'h5A);
        wr(8'h40, 8'h33);
        rc(8'h40, 8'h00);
        wr(OFS_MASK, 8'h00);
        $display("read write done");
    endtask
    task automatic t_flags;
        logic [7:0] b [3];
        b = '{8'h02, 8'h01, 8'h08};
        wr(OFS_CTRLA, 8'h44);
        wr(OFS_FLAG, 8'h1F);
        rc(OFS_FLAG, 8'h00);
        pulse(0);
        rc(OFS_FLAG, 8'h04);
        chk(irq, 1'b0);
        wr(OFS_MASK, 8'h04);
        cyc(2);
        chk(irq, 1'b1);
        gmask <= 1'b1;
        cyc(2);
        chk(irq, 1'b0);
        gmask <= 1'b0;
        wr(OFS_FLAG, 8'hFB);
        rc(OFS_FLAG, 8'h00);
        // the demag end flag only rises with a demag mode on
        wr(OFS_AUX, 8'h01);
        for (int k = 1; k < 4; k++) begin
            pulse(k);
            rc(OFS_FLAG, b[k-1]);
            wr(OFS_FLAG, ~b[k-1]);
        end
        wr(OFS_MASK, 8'h02);
        req.demag_count <= 8'h77;
        pulse(1);
        chk(irq, 1'b1);
        rc(OFS_DEMAG, 8'h77);
        // pending flag stays, but its request drops with both demag modes off
        wr(OFS_AUX, 8'h00);
        cyc(2);
        chk(irq, 1'b0);
        wr(OFS_FLAG, 8'hFD);
        wr(OFS_MASK, 8'h00);
        $display("flags done");
    endtask
    task automatic t_mult;
        logic [15:0] p;
        wr(OFS_GAIN, 8'h80);
        wr(OFS_CTRLA, 8'h45);
        req.zero_cur <= 8'hC8;
        req.zero_prev <= 8'h40;
        pulse(0);
        p = 16'h0080 * 16'h00C8;
        rc(OFS_NCC, p[15:8]);
        chk(ncc, p[15:8]);
        wr(OFS_CTRLA, 8'h44);
        pulse(0);
        p = 16'h0080 * 16'h0040;
        rc(OFS_NCC, p[15:8]);
        wr(OFS_FLAG, 8'hFB);
        $display("multiplier done");
    endtask
    task automatic t_limit;
        pulse(4);
        rc(OFS_FLAG, 8'h10);
        wr(OFS_FLAG, 8'hEF);
        wr(OFS_CTRLA, 8'h4C);
        pulse(4);
        rc(OFS_FLAG, 8'h00);
        wr(OFS_CTRLA, 8'h04);
        cyc(2);
        chk(cke, 1'b0);
        wr(OFS_DEMAG, 8'h5C);
        rc(OFS_DEMAG, 8'h5C);
        pulse(0);
        rc(OFS_FLAG, 8'h00);
        $display("limit and clock done");
    endtask
    task automatic t_resync;
        int n;
        n = 0;
        wr(OFS_CTRLA, 8'h44);
        wr(OFS_FLAG, RESYNC_VAL);
        repeat (4) begin
            @(posedge core_clk);
            if (resync === 1'b1) n++;
        end
        chk(n, 1);
        rc(OFS_FLAG, 8'h80);
        wr(OFS_FLAG, 8'h7F);
        pulse(5);
        rc(OFS_FLAG, 8'h80);
        wr(OFS_FLAG, 8'h7F);
        wr(OFS_PRESC, 8'h03);
        pulse(6);
        rc(OFS_PRESC, 8'h04);
        rc(OFS_FLAG, 8'h40);
        pulse(7);
        rc(OFS_PRESC, 8'h03);
        rc(OFS_FLAG, 8'h60);
        wr(OFS_FLAG, 8'h9F);
        $display("resync and ratio done");
    endtask
    task automatic t_switched;
        wr(OFS_CTRLA, 8'h40);
        wr(OFS_PRESC, 8'h05);
        wr(OFS_FLAG, 8'h9F);
        wr(OFS_FLAG, 8'hBF);
        rc(OFS_FLAG, 8'h20);
        pulse(2);
        chk(nl, 1);
        rc(OFS_PRESC, 8'h04);
        wr(OFS_FLAG, 8'hDF);
        pulse(2);
        chk(nr, 1);
        chk(nl, 1);
        rc(OFS_PRESC, 8'h05);
        wr(OFS_FLAG, 8'h9E);
        $display("switched done");
    endtask
    // speed sensor mode: demag value against the speed counter
    task automatic t_speed;
        wr(OFS_AUX, 8'h10);
        wr(OFS_DEMAG, 8'h20);
        req.speed_counter <= 8'h30;
        cyc(3);
        rc(OFS_SPDST, 8'h40);
        wr(OFS_MASK, 8'h40);
        cyc(2);
        chk(irq, 1'b1);
        wr(OFS_SPDST, 8'h00);
        rc(OFS_SPDST, 8'h00);
        pulse(6);
        rc(OFS_FLAG, 8'h40);
        wr(OFS_FLAG, 8'h9F);
        wr(OFS_MASK, 8'h00);
        wr(OFS_AUX, 8'h00);
        req.speed_counter <= 8'h00;
        $display("speed mode done");
    endtask
    task automatic t_pins;
        opt <= RS_HIZ;
        cyc(2);
        chk(oe, 6'h00);
        chk(zse, 1'b0);
        chk(dse, 1'b1);
        wr(OFS_AUX, 8'h08);
        // the sampling enable is a flop behind the freshly written register
        cyc(2);
        chk(zse, 1'b1);
        opt <= RS_HIGH;
        cyc(2);
        chk(pinw, 6'h3F);
        opt <= 2'h2;
        cyc(2);
        chk(pins, 6'h00);
        chk(oe, 6'h3F);
        wr(OFS_CTRLA, 8'hC0);
        cyc(2);
        chk(pinw, drive);
        $display("pins done");
    endtask
    // ==========================================
    // run
    initial begin
        cyc(8);
        rst_n <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_rw();
        t_flags();
        t_mult();
        t_limit();
        t_resync();
        t_switched();
        t_speed();
        t_pins();
        complete_run();
    end
    // the whole run needs about four hundred cycles; 20000 means a hang
    initial begin
        #200us;
        failures++;
        complete_run();
    end
endmodule
`default_nettype wire
